// *** dv/flash_model.sv ***
`timescale 1ns/1ps

// Parallel NOR flash: async reads, read-config write, burst reads.
module flash_model (
    input  wire logic        clk_in,   // Config clock.
    input  wire logic        rst_in,   // Bench reset.
    input  wire logic        cs_n_in,  // Chip select.
    input  wire logic        oe_n_in,  // Output enable.
    input  wire logic        we_n_in,  // Write enable.
    input  wire logic        adv_n_in, // Address valid.
    input  wire logic [28:0] a_in,     // Address.
    input  wire logic [15:0] d_in,     // Write data.
    output logic      [15:0] q_out     // Read data.
);
    logic [15:0] mem [0:63];
    logic [15:0] read_cfg = 16'h0000;
    logic        setup = 0;
    logic        sync = 0;
    logic        adv_s = 1;
    logic        cs_s = 1;
    int          lat = 0;
    int          ba = 0;
    initial for (int i = 0; i < 64; i++) mem[i] = 16'hA500 + 16'(i);
    always @(posedge rst_in) {setup, sync} = 2'b00;
    // The config value rides on A16..A1 in both write cycles.
    always @(posedge we_n_in)
        if (d_in === 16'h0060) {read_cfg, setup} = {a_in[16:1], 1'b1};
        else if (setup && d_in === 16'h0003 && a_in[16:1] === read_cfg) sync = 1;
    // A released bus shows the inverse of its last value.
    always @(a_in, cs_n_in, oe_n_in)
        if (!sync) q_out = (!cs_n_in && !oe_n_in) ? mem[a_in[5:0]] : ~q_out;
    // Controls change on the clock's rise, so the flash takes the values from before it.
    always @(negedge clk_in) {adv_s, cs_s} = {adv_n_in, cs_n_in};
    always @(posedge clk_in)
        if (sync && !adv_s && !cs_s)
        begin
            ba = int'(a_in[5:0]);
            lat = (read_cfg[13:11] < 2) ? 1 : int'(read_cfg[13:11]);
            q_out = ~q_out;
        end
        else if (sync && lat > 1) {lat, q_out} = {lat - 1, ~q_out};
        else if (sync && !cs_s)
        begin
            q_out = mem[ba];
            ba = ba + 1;
        end
        else if (sync) q_out = ~q_out;
endmodule : flash_model

// *** dv/nor_flash_sync_burst_config_reader_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module nor_flash_sync_burst_config_reader_tb;
    logic        clk = 0, srst = 1, ext = 0, done = 0;
    logic [2:0]  mode = 3'h2;
    logic [28:0] addr;
    logic [15:0] dq, dout, q, word;
    logic        init, init_oe, dq_oe, cs_n, oe_n, we_n, adv_n, config_clock, wv, sm, ce, wrap;
    int          errors = 0, compares = 0;
    always #50 clk = ~clk;
    always #3 ext = ~ext;
    assign dq = dq_oe ? dout : q;
    nor_flash_sync_burst_config_reader i_nor_flash_sync_burst_config_reader (
        .core_clk_in(clk), .srst_in(srst), .external_master_clock_input_in(ext),
        .mode_select_pins_in(mode), .initialization_release_n_in(init_oe ? init : 1'b1),
        .initialization_release_n_out(init), .initialization_release_n_oe_out(init_oe),
        .load_done_in(done), .flash_address_out(addr), .flash_data_in(dq),
        .flash_data_out(dout), .flash_data_oe_out(dq_oe), .flash_chip_select_n_out(cs_n),
        .flash_output_enable_n_out(oe_n), .flash_write_enable_n_out(we_n),
        .address_valid_n_out(adv_n), .config_clock_out(config_clock), .word_out(word),
        .word_valid_out(wv), .sync_mode_out(sm), .clock_external_out(ce),
        .wrap_error_out(wrap));
    flash_model i_flash_model (.clk_in(config_clock), .rst_in(srst), .cs_n_in(cs_n),
        .oe_n_in(oe_n), .we_n_in(we_n), .adv_n_in(adv_n), .a_in(addr), .d_in(dq),
        .q_out(q));
    task final_report;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task restart(input logic [15:0] opt, input logic [2:0] m);
        @(posedge clk);
        #1 {srst, done, mode} = {2'b10, m};
        i_flash_model.mem[0] = opt;
        i_flash_model.mem[1] = 16'h1800;
        repeat (5) @(posedge clk);
        #1 srst = 0;
    endtask : restart
    // Body words always start at address 2; a narrow bus pairs low bytes, high byte first.
    task words(input int n, input logic x8);
        int          t;
        logic [15:0] exp;
        for (int k = 0; k < n; k++)
        begin
            t = 0;
            do begin @(posedge clk); #1 t++; end while (wv !== 1'b1 && t < 3000);
            if (t >= 3000) errors++;
            exp = x8 ? {8'(2 * k + 2), 8'(2 * k + 3)} : 16'hA502 + 16'(k);
            `CHK("word", exp, word)
        end
        done = 1;
    endtask : words
    task t_async;
        restart(16'h0002, 3'h2);
        words(4, 1'b0);
        `CHK("sync", 1'b0, sm)
        `CHK("wrap", 1'b0, wrap)
        `CHK("wr", 1'b0, i_flash_model.setup)
        $display("async done");
    endtask : t_async
    task t_sync(input logic [15:0] opt, input logic e);
        restart(opt, 3'h2);
        words(4, 1'b0);
        `CHK("sync", 1'b1, sm)
        `CHK("read_cfg", 16'h1800, i_flash_model.read_cfg)
        `CHK("cfm", 1'b1, i_flash_model.sync)
        `CHK("ext", e, ce)
        $display("sync done");
    endtask : t_sync
    task t_misc;
        restart(16'h0001, 3'h2);
        words(2, 1'b1);
        `CHK("x8", 1'b0, sm)
        restart(16'h0002, 3'h1);
        repeat (300) @(posedge clk);
        `CHK("cs", 1'b1, cs_n)
        $display("misc done");
    endtask : t_misc
    initial
    begin
        t_async();
        t_sync(16'h0023, 1'b0);
        t_sync(16'h0027, 1'b1);
        t_misc();
        final_report();
    end
    initial
    begin
        #3000000 errors++;
        final_report();
    end
endmodule : nor_flash_sync_burst_config_reader_tb

// *** src/level_sync.sv ***
`timescale 1ns/1ps

// Two-flop synchroniser for levels entering a clock domain.
module level_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,  // Destination clock.
    input  wire logic             rst_in,  // Synchronous reset, active high.
    input  wire logic [WIDTH-1:0] d_in,    // Asynchronous level.
    output logic      [WIDTH-1:0] q_out    // Synchronised level.
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_type;

    sync_state_type q;
    sync_state_type next_q;

    always_comb
    begin
        next_q        = q;
        next_q.meta   = d_in;
        next_q.stable = q.meta;
        if (rst_in)
        begin
            next_q = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        q <= next_q;
    end

    assign q_out = q.stable;

endmodule : level_sync

// *** src/nor_flash_sync_burst_config_reader.sv ***
`timescale 1ns/1ps

// What this block does
// - Synchronous burst only with x16 data; x8 flash is read asynchronously only.
// - Address-valid and config clock are driven out for the flash in every mode.
// - Read data is always sampled on config_clock, which times every flash cycle.
// - Load starts by itself after reset when mode pins equal 010.
// - Reading always begins asynchronous at the default internal clock rate.
// - After init release, assert select, output enable, address valid; capture data.
// - Parse header option; on a synchronous request write the flash read config.
// - During the config write assert select and write enable, keep OE, init high.
// - First write cycle: config value on A16..A1, command 0x60 on data.
// - Second write cycle: same config value on A16..A1, command 0x03 on data.
// - The config value written comes from the header, not a fixed constant.
// - Then restart synchronous read: select, OE low, address valid one clock.
// - Clock source or rate changes only after the header has been read.
// - The flash read mode is never restored after the load.
// - config_clock is generated internally by default.
// - Internal rate follows the header setting; an option selects the external clock.
// - Switching to the external clock happens mid-load without interrupting it.
// - Mode pins are sampled when initialization release goes high.
// - Address launches after a rising clock edge; data sampled at the next one.
module nor_flash_sync_burst_config_reader (
    input  wire logic        core_clk_in,                      // Core clock, 10 MHz.
    input  wire logic        srst_in,                          // Synchronous reset.
    input  wire logic        external_master_clock_input_in,   // External clock pin.
    input  wire logic [2:0]  mode_select_pins_in,              // Mode strap pins.
    input  wire logic        initialization_release_n_in,      // Init pin level.
    output logic             initialization_release_n_out,     // Init pin drive value.
    output logic             initialization_release_n_oe_out,  // Init pin pull-down on.
    input  wire logic        load_done_in,                     // Load complete.
    output logic [28:0]      flash_address_out,                // Flash address.
    input  wire logic [15:0] flash_data_in,                    // Flash data pins.
    output logic [15:0]      flash_data_out,                   // Flash data drive.
    output logic             flash_data_oe_out,                // Flash data drive on.
    output logic             flash_chip_select_n_out,          // Flash select.
    output logic             flash_output_enable_n_out,        // Flash output enable.
    output logic             flash_write_enable_n_out,         // Flash write enable.
    output logic             address_valid_n_out,              // Flash address valid.
    output logic             config_clock_out,                 // Config clock.
    output logic [15:0]      word_out,                         // Bitstream word.
    output logic             word_valid_out,                   // Word strobe.
    output logic             sync_mode_out,                    // Burst mode active.
    output logic             clock_external_out,               // External clock used.
    output logic             wrap_error_out                    // Address wrapped.
);

    typedef enum logic [3:0] {
        ST_HOLD, ST_WAIT_INIT, ST_HDR_READ, ST_WR1, ST_WR1_GAP, ST_WR2, ST_WR2_GAP,
        ST_SYNC_ADV, ST_SYNC_LAT, ST_BURST, ST_BODY, ST_DONE, ST_IDLE, ST_ERROR
    } st_type;

    typedef struct packed {
        st_type       state;
        logic [3:0]   hold_cnt;
        logic [2:0]   mode;
        logic [28:0]  addr;
        logic         pending;
        logic         cfg_clk;
        logic [3:0]   half_cnt;
        logic [3:0]   half;
        logic         ext_sel;
        logic         ext_seen;
        logic         sync_mode;
        logic         bus_x16;
        logic         ext_req;
        logic [3:0]   rate;
        logic [15:0]  read_cfg;
        logic         hdr_done;
        logic [2:0]   lat_cnt;
        logic [1:0]   skip_cnt;
        logic [7:0]   byte_hi;
        logic         byte_half;
        logic [15:0]  word;
        logic         word_valid;
        logic         wrap_err;
        logic         cs_n;
        logic         oe_n;
        logic         we_n;
        logic         adv_n;
        logic [15:0]  dq;
        logic         dq_oe;
        logic         init_oe;
    } core_state_type;

    typedef struct packed {
        logic [nor_load_pkg::EXT_DIV_BITS-1:0] div;
        logic                                  lvl;
    } ext_state_type;

    core_state_type q;
    core_state_type next_q;
    ext_state_type  eq;
    ext_state_type  next_eq;

    logic        ext_rst;
    logic        ext_lvl;
    logic        init_pin;
    logic [2:0]  mode_pins;
    logic [15:0] dq_in;
    logic        tick;
    logic        rise;
    logic [3:0]  opt_rate;

    level_sync #(.WIDTH(1)) u_ext_rst (
        .clk_in (external_master_clock_input_in),
        .rst_in (1'b0),
        .d_in   (srst_in),
        .q_out  (ext_rst)
    );

    level_sync #(.WIDTH(1)) u_ext_lvl (
        .clk_in (core_clk_in),
        .rst_in (srst_in),
        .d_in   (eq.lvl),
        .q_out  (ext_lvl)
    );

    level_sync #(.WIDTH(4)) u_pins (
        .clk_in (core_clk_in),
        .rst_in (srst_in),
        .d_in   ({initialization_release_n_in, mode_select_pins_in}),
        .q_out  ({init_pin, mode_pins})
    );

    level_sync #(.WIDTH(16)) u_data (
        .clk_in (core_clk_in),
        .rst_in (srst_in),
        .d_in   (flash_data_in),
        .q_out  (dq_in)
    );

    // Divided external clock; each change of its level is one config_clock half period.
    always_comb
    begin
        next_eq     = eq;
        next_eq.div = eq.div + 1'b1;
        if (&eq.div)
        begin
            next_eq.lvl = ~eq.lvl;
        end
        if (ext_rst)
        begin
            next_eq = '0;
        end
    end

    always_ff @(posedge external_master_clock_input_in)
    begin
        eq <= next_eq;
    end

    assign tick     = q.ext_sel ? (ext_lvl != q.ext_seen) : (q.half_cnt == q.half - 4'h1);
    assign rise     = tick && !q.cfg_clk;
    assign opt_rate = dq_in[nor_load_pkg::OPT_RATE_MSB:nor_load_pkg::OPT_RATE_LSB];

    always_comb
    begin
        next_q            = q;
        next_q.word_valid = 1'b0;
        next_q.ext_seen   = ext_lvl;
        next_q.half_cnt   = tick ? 4'h0 : q.half_cnt + 4'h1;
        if (tick)
        begin
            next_q.cfg_clk = ~q.cfg_clk;
        end
        if (rise && q.hdr_done)
        begin
            next_q.ext_sel = q.ext_req;
            next_q.half    = q.rate;
        end
        case (q.state)
            ST_HOLD:
            begin
                next_q.hold_cnt = q.hold_cnt + 4'h1;
                if (q.hold_cnt == 4'(nor_load_pkg::INIT_HOLD_CYC - 1))
                begin
                    next_q.init_oe = 1'b0;
                    next_q.state   = ST_WAIT_INIT;
                end
            end
            ST_WAIT_INIT:
            begin
                if (init_pin)
                begin
                    next_q.mode = mode_pins;
                    if (mode_pins == nor_load_pkg::MODE_PARALLEL_NOR)
                    begin
                        next_q.cs_n    = 1'b0;
                        next_q.oe_n    = 1'b0;
                        next_q.adv_n   = 1'b0;
                        next_q.addr    = nor_load_pkg::HDR_OPT_ADDR;
                        next_q.pending = 1'b0;
                        next_q.state   = ST_HDR_READ;
                    end
                    else
                    begin
                        next_q.state = ST_IDLE;
                    end
                end
            end
            ST_HDR_READ:
            begin
                if (rise)
                begin
                    next_q.pending = 1'b1;
                    if (q.pending)
                    begin
                        next_q.addr = q.addr + 29'h0000_0001;
                        if (q.addr == nor_load_pkg::HDR_OPT_ADDR)
                        begin
                            next_q.bus_x16 = dq_in[nor_load_pkg::OPT_X16_BIT];
                            next_q.ext_req = dq_in[nor_load_pkg::OPT_EXT_BIT];
                            next_q.rate    = (opt_rate < nor_load_pkg::HALF_MIN) ?
                                             nor_load_pkg::HALF_DEFAULT : opt_rate;
                            next_q.sync_mode = 1'b0;
                            next_q.ext_sel   = 1'b0;
                            next_q.lat_cnt   = {2'h0, dq_in[nor_load_pkg::OPT_SYNC_BIT]};
                        end
                        else
                        begin
                            next_q.read_cfg = dq_in;
                            next_q.hdr_done = 1'b1;
                            if (q.lat_cnt[0] && q.bus_x16)
                            begin
                                next_q.oe_n  = 1'b1;
                                next_q.adv_n = 1'b1;
                                next_q.we_n  = 1'b0;
                                next_q.addr  = {12'h000, dq_in, 1'b0};
                                next_q.dq    = nor_load_pkg::CMD_READ_CFG_SETUP;
                                next_q.dq_oe = 1'b1;
                                next_q.state = ST_WR1;
                            end
                            else
                            begin
                                next_q.addr    = nor_load_pkg::BODY_ADDR;
                                next_q.pending = 1'b0;
                                next_q.state   = ST_BODY;
                            end
                        end
                    end
                end
            end
            ST_WR1:
            begin
                if (rise)
                begin
                    next_q.we_n  = 1'b1;
                    next_q.cs_n  = 1'b1;
                    next_q.state = ST_WR1_GAP;
                end
            end
            ST_WR1_GAP:
            begin
                if (rise)
                begin
                    next_q.cs_n  = 1'b0;
                    next_q.we_n  = 1'b0;
                    next_q.dq    = nor_load_pkg::CMD_READ_CFG_CONFIRM;
                    next_q.state = ST_WR2;
                end
            end
            ST_WR2:
            begin
                if (rise)
                begin
                    next_q.we_n  = 1'b1;
                    next_q.cs_n  = 1'b1;
                    next_q.state = ST_WR2_GAP;
                end
            end
            ST_WR2_GAP:
            begin
                if (rise)
                begin
                    next_q.dq_oe     = 1'b0;
                    next_q.sync_mode = 1'b1;
                    next_q.addr      = nor_load_pkg::HDR_OPT_ADDR;
                    next_q.cs_n      = 1'b0;
                    next_q.oe_n      = 1'b0;
                    next_q.adv_n     = 1'b0;
                    next_q.state     = ST_SYNC_ADV;
                end
            end
            ST_SYNC_ADV:
            begin
                if (rise)
                begin
                    next_q.adv_n   = 1'b1;
                    next_q.lat_cnt = q.read_cfg[nor_load_pkg::READ_CFG_LAT_MSB:
                                                nor_load_pkg::READ_CFG_LAT_LSB];
                    next_q.skip_cnt = 2'h0;
                    next_q.state   = ST_SYNC_LAT;
                end
            end
            ST_SYNC_LAT:
            begin
                if (rise)
                begin
                    next_q.lat_cnt = q.lat_cnt - 3'h1;
                    if (q.lat_cnt <= 3'h1)
                    begin
                        next_q.state = ST_BURST;
                    end
                end
            end
            ST_BURST:
            begin
                if (rise)
                begin
                    if (q.skip_cnt < nor_load_pkg::HDR_WORDS)
                    begin
                        next_q.skip_cnt = q.skip_cnt + 2'h1;
                    end
                    else
                    begin
                        next_q.word       = dq_in;
                        next_q.word_valid = 1'b1;
                    end
                end
            end
            ST_BODY:
            begin
                if (rise)
                begin
                    next_q.pending = 1'b1;
                    if (q.pending)
                    begin
                        next_q.addr = q.addr + 29'h0000_0001;
                        if (q.bus_x16)
                        begin
                            next_q.word       = dq_in;
                            next_q.word_valid = 1'b1;
                        end
                        else if (q.byte_half)
                        begin
                            next_q.word       = {q.byte_hi, dq_in[7:0]};
                            next_q.word_valid = 1'b1;
                            next_q.byte_half  = 1'b0;
                        end
                        else
                        begin
                            next_q.byte_hi   = dq_in[7:0];
                            next_q.byte_half = 1'b1;
                        end
                        if (q.addr == nor_load_pkg::ADDR_MAX)
                        begin
                            next_q.wrap_err = 1'b1;
                            next_q.state    = ST_ERROR;
                        end
                    end
                end
            end
            ST_DONE, ST_ERROR:
            begin
                next_q.cs_n  = 1'b1;
                next_q.oe_n  = 1'b1;
                next_q.adv_n = 1'b1;
            end
            ST_IDLE:
            begin
                next_q.state = ST_IDLE;
            end
            default:
            begin
                next_q.state = ST_ERROR;
            end
        endcase
        if (load_done_in && (q.state == ST_BODY || q.state == ST_BURST ||
                             q.state == ST_HDR_READ))
        begin
            next_q.state = ST_DONE;
        end
        if (srst_in)
        begin
            next_q          = '0;
            next_q.state    = ST_HOLD;
            next_q.half     = nor_load_pkg::HALF_DEFAULT;
            next_q.rate     = nor_load_pkg::HALF_DEFAULT;
            next_q.cs_n     = 1'b1;
            next_q.oe_n     = 1'b1;
            next_q.we_n     = 1'b1;
            next_q.adv_n    = 1'b1;
            next_q.init_oe  = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        q <= next_q;
    end

    assign initialization_release_n_out    = 1'b0;
    assign initialization_release_n_oe_out = q.init_oe;
    assign flash_address_out               = q.addr;
    assign flash_data_out                  = q.dq;
    assign flash_data_oe_out               = q.dq_oe;
    assign flash_chip_select_n_out         = q.cs_n;
    assign flash_output_enable_n_out       = q.oe_n;
    assign flash_write_enable_n_out        = q.we_n;
    assign address_valid_n_out             = q.adv_n;
    assign config_clock_out                = q.cfg_clk;
    assign word_out                        = q.word;
    assign word_valid_out                  = q.word_valid;
    assign sync_mode_out                   = q.sync_mode;
    assign clock_external_out              = q.ext_sel;
    assign wrap_error_out                  = q.wrap_err;

    property p_write_controls;
        @(posedge core_clk_in) disable iff (srst_in)
        (q.state == ST_WR1 || q.state == ST_WR2) |->
            !flash_chip_select_n_out && !flash_write_enable_n_out &&
            flash_output_enable_n_out && !initialization_release_n_oe_out;
    endproperty
    a_write_controls: assert property (p_write_controls) else $error("write controls wrong");

    property p_first_write;
        @(posedge core_clk_in) disable iff (srst_in)
        q.state == ST_WR1 |-> flash_data_out == 16'h0060 && flash_data_oe_out &&
            flash_address_out[16:1] == q.read_cfg;
    endproperty
    a_first_write: assert property (p_first_write) else $error("first write cycle wrong");

    property p_second_write;
        @(posedge core_clk_in) disable iff (srst_in)
        q.state == ST_WR2 |-> flash_data_out == 16'h0003 && flash_data_oe_out &&
            flash_address_out[16:1] == q.read_cfg;
    endproperty
    a_second_write: assert property (p_second_write) else $error("second write cycle wrong");

    property p_adv_pulse;
        @(posedge core_clk_in) disable iff (srst_in)
        (sync_mode_out && !address_valid_n_out) |-> q.state == ST_SYNC_ADV &&
            !flash_chip_select_n_out && !flash_output_enable_n_out;
    endproperty
    a_adv_pulse: assert property (p_adv_pulse) else $error("address valid outside pulse");

    property p_sync_x16;
        @(posedge core_clk_in) disable iff (srst_in)
        sync_mode_out |-> q.bus_x16;
    endproperty
    a_sync_x16: assert property (p_sync_x16) else $error("burst on narrow bus");

    property p_async_start;
        @(posedge core_clk_in) disable iff (srst_in)
        (q.state == ST_HDR_READ && !q.hdr_done) |->
            !sync_mode_out && !clock_external_out && q.half == 4'h4;
    endproperty
    a_async_start: assert property (p_async_start) else $error("start not default async");

    property p_capture_on_rise;
        @(posedge core_clk_in) disable iff (srst_in)
        word_valid_out |-> $past(rise) && config_clock_out;
    endproperty
    a_capture_on_rise: assert property (p_capture_on_rise) else $error("capture off edge");

    property p_clock_switch_late;
        @(posedge core_clk_in) disable iff (srst_in)
        $changed(clock_external_out) |-> $past(q.hdr_done);
    endproperty
    a_clock_switch_late: assert property (p_clock_switch_late) else $error("early switch");

    property p_mode_kept;
        @(posedge core_clk_in) disable iff (srst_in)
        q.state == ST_DONE |=> q.state == ST_DONE && $stable(sync_mode_out);
    endproperty
    a_mode_kept: assert property (p_mode_kept) else $error("read mode changed after load");

    property p_mode_sample;
        @(posedge core_clk_in) disable iff (srst_in)
        (q.state == ST_WAIT_INIT && init_pin) |=> q.mode == $past(mode_pins);
    endproperty
    a_mode_sample: assert property (p_mode_sample) else $error("mode not sampled");

endmodule : nor_flash_sync_burst_config_reader

// *** src/nor_load_pkg.sv ***
package nor_load_pkg;

    // Flash bus geometry.
    localparam int unsigned ADDR_W = 29;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned READ_CFG_W = 16;

    // Configuration mode strap that selects the parallel NOR master load.
    localparam logic [2:0] MODE_PARALLEL_NOR = 3'h2;

    // Read-configuration write commands, first and second cycle.
    localparam logic [15:0] CMD_READ_CFG_SETUP   = 16'h0060;
    localparam logic [15:0] CMD_READ_CFG_CONFIRM = 16'h0003;

    // Header layout: option word, then read-configuration word, then body.
    localparam logic [28:0] HDR_OPT_ADDR  = 29'h0000_0000;
    localparam logic [28:0] HDR_READ_CFG_ADDR = 29'h0000_0001;
    localparam logic [28:0] BODY_ADDR     = 29'h0000_0002;
    localparam logic [28:0] ADDR_MAX      = 29'h1FFF_FFFF;
    localparam logic [1:0]  HDR_WORDS     = 2'h2;

    // Option word fields.
    localparam int unsigned OPT_SYNC_BIT  = 0;
    localparam int unsigned OPT_X16_BIT   = 1;
    localparam int unsigned OPT_EXT_BIT   = 2;
    localparam int unsigned OPT_RATE_LSB  = 4;
    localparam int unsigned OPT_RATE_MSB  = 7;

    // Latency field inside the read-configuration word.
    localparam int unsigned READ_CFG_LAT_LSB = 11;
    localparam int unsigned READ_CFG_LAT_MSB = 13;

    // Internal clock: half period of config_clock in core cycles.
    localparam logic [3:0] HALF_DEFAULT   = 4'h4;
    localparam logic [3:0] HALF_MIN       = 4'h2;

    // External clock is divided before crossing so each edge survives the synchroniser.
    localparam int unsigned EXT_DIV_BITS  = 6;

    // Initialization release is held low this long after reset.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned INIT_HOLD_NS  = 1000;
    localparam int unsigned INIT_HOLD_CYC = (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : nor_load_pkg
